// ### rtl/ext_irq_config_priority.sv
// The APB slave port was decided locally.
`timescale 1ns/100ps
// What this block does
// - Low priority register holds priority LSBs for four sources, reset zero.
// - High priority register holds matching MSBs; fields pair MSB with LSB.
// - Each external input has a polarity bit: 0 active low, 1 high.
// - Sense mode bit: 1 edge, 0 level; four combinations with polarity.
// - Three-bit pin select per input chooses port-0 pin n.
// - Selected pin is sampled without disturbing any crossbar peripheral.
// - Pending flags sit at bits 1 and 3 of timer control register.
// - Edge mode pending flag clears when the CPU vectors to it.
// - Level mode pending flag follows the active level of the input.
module ext_irq_config_priority
	import ext_irq_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              reset_in,
	input  wire logic              psel_in,
	input  wire logic              penable_in,
	input  wire logic              pwrite_in,
	input  wire logic [31:0]       paddr_in,
	input  wire logic [31:0]       pwdata_in,
	output logic      [31:0]       prdata_out,
	output logic                   pready_out,
	output logic                   pslverr_out,
	input  wire logic [7:0]        port0_pins_in,
	input  wire logic [1:0]        vector_ack_in,
	output logic      [1:0]        ext_irq_request_out,
	output logic      [1:0]        tempsense_prio_out,
	output logic      [1:0]        timer5_prio_out,
	output logic      [1:0]        timer4_prio_out,
	output logic      [1:0]        serial1_prio_out,
	output logic                   irq_out
);
	typedef struct packed {
		logic [7:0]  prio_lo;
		logic [7:0]  prio_hi;
		logic [7:0]  pin_cfg;
		logic [1:0]  edge_mode;
		logic [1:0]  status;
		logic [1:0]  mask;
		logic [31:0] rdata;
	} regs_s;
	regs_s state_q;
	regs_s state_d;
	logic [7:0] pins_sync;
	logic [1:0] pending;
	logic [1:0] edge_evt;
	logic       wr_en;
	logic       rd_en;
	logic       addr_ok;
	logic [1:0] sw_ack;
	logic       sel_pin_a;
	logic       sel_pin_b;
	logic [3:0] wr_nibble;

	function automatic logic [1:0] prio_pair(input logic [7:0] hi, input logic [7:0] lo,
			input int idx);
		prio_pair = {hi[idx], lo[idx]};
	endfunction

	// Monitoring only reads the pins, never drives them
	pin_sync u_sync (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.pins_in  (port0_pins_in),
		.pins_out (pins_sync)
	);

	irq_detect u_det_a (
		.clk_in        (clk_in),
		.reset_in      (reset_in),
		.pins_in       (pins_sync),
		.pin_sel_in    (state_q.pin_cfg[A_SEL_LSB +: 3]),
		.polarity_in   (state_q.pin_cfg[A_POL_BIT]),
		.edge_mode_in  (state_q.edge_mode[0]),
		.vector_ack_in (vector_ack_in[0] | sw_ack[0]),
		.pending_out   (pending[0]),
		.active_out    (),
		.edge_out      (edge_evt[0])
	);

	irq_detect u_det_b (
		.clk_in        (clk_in),
		.reset_in      (reset_in),
		.pins_in       (pins_sync),
		.pin_sel_in    (state_q.pin_cfg[B_SEL_LSB +: 3]),
		.polarity_in   (state_q.pin_cfg[B_POL_BIT]),
		.edge_mode_in  (state_q.edge_mode[1]),
		.vector_ack_in (vector_ack_in[1] | sw_ack[1]),
		.pending_out   (pending[1]),
		.active_out    (),
		.edge_out      (edge_evt[1])
	);

	assign addr_ok = (paddr_in[31:ADDR_W] == '0) &&
		(paddr_in[9:0] == PRIO_HI_ADDR || paddr_in[9:0] == PRIO_LO_ADDR ||
		 paddr_in[9:0] == PIN_CFG_ADDR || paddr_in[9:0] == TIMER_CTRL_ADDR ||
		 paddr_in[9:0] == IRQ_STATUS_ADDR || paddr_in[9:0] == IRQ_MASK_ADDR ||
		 paddr_in[9:0] == VECTOR_ACK_ADDR);
	assign wr_en  = psel_in && penable_in && pwrite_in && addr_ok;
	assign rd_en  = psel_in && !penable_in && !pwrite_in;
	assign sw_ack = (wr_en && paddr_in[9:0] == VECTOR_ACK_ADDR) ? pwdata_in[1:0] : 2'b00;
	assign sel_pin_a = pins_sync[state_q.pin_cfg[A_SEL_LSB +: 3]];
	assign sel_pin_b = pins_sync[state_q.pin_cfg[B_SEL_LSB +: 3]];
	assign wr_nibble = pwdata_in[3:0];

	always_comb begin
		state_d = state_q;
		if (wr_en) begin
			unique case (paddr_in[9:0])
				PRIO_LO_ADDR: state_d.prio_lo = {4'h0, pwdata_in[3:0]};
				PRIO_HI_ADDR: state_d.prio_hi = {4'h0, pwdata_in[3:0]};
				PIN_CFG_ADDR: state_d.pin_cfg = pwdata_in[7:0];
				TIMER_CTRL_ADDR: begin
					state_d.edge_mode = {pwdata_in[B_EDGE_BIT], pwdata_in[A_EDGE_BIT]};
				end
				IRQ_STATUS_ADDR: state_d.status = state_q.status & ~pwdata_in[1:0];
				IRQ_MASK_ADDR: state_d.mask = pwdata_in[1:0];
				default: state_d.rdata = state_q.rdata;
			endcase
		end
		// Set wins over a same-cycle clear
		state_d.status = state_d.status | edge_evt | (pending & ~state_q.edge_mode);
		if (rd_en) begin
			state_d.rdata = 32'h0000_0000;
			unique case (paddr_in[9:0])
				PRIO_LO_ADDR: state_d.rdata = {24'h0, state_q.prio_lo};
				PRIO_HI_ADDR: state_d.rdata = {24'h0, state_q.prio_hi};
				PIN_CFG_ADDR: state_d.rdata = {24'h0, state_q.pin_cfg};
				TIMER_CTRL_ADDR: begin
					state_d.rdata[A_EDGE_BIT] = state_q.edge_mode[0];
					state_d.rdata[A_PEND_BIT] = pending[0];
					state_d.rdata[B_EDGE_BIT] = state_q.edge_mode[1];
					state_d.rdata[B_PEND_BIT] = pending[1];
				end
				IRQ_STATUS_ADDR: state_d.rdata = {30'h0, state_q.status};
				IRQ_MASK_ADDR: state_d.rdata = {30'h0, state_q.mask};
				default: state_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_q.prio_lo   <= PRIO_RESET;
			state_q.prio_hi   <= PRIO_RESET;
			state_q.pin_cfg   <= PIN_CFG_RESET;
			state_q.edge_mode <= EDGE_MODE_RESET;
			state_q.status    <= STATUS_RESET;
			state_q.mask      <= MASK_RESET;
			state_q.rdata     <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
		end
	end

	assign pready_out          = 1'b1;
	assign pslverr_out         = psel_in && penable_in && !addr_ok;
	assign prdata_out          = state_q.rdata;
	assign ext_irq_request_out = pending;
	assign tempsense_prio_out  = prio_pair(state_q.prio_hi, state_q.prio_lo, 3);
	assign timer5_prio_out     = prio_pair(state_q.prio_hi, state_q.prio_lo, 2);
	assign timer4_prio_out     = prio_pair(state_q.prio_hi, state_q.prio_lo, 1);
	assign serial1_prio_out    = prio_pair(state_q.prio_hi, state_q.prio_lo, 0);
	assign irq_out             = |(state_q.status & state_q.mask);

	prio_reset_a: assert property (@(posedge clk_in)
		$past(reset_in) |-> state_q.prio_lo == 8'h00 && state_q.prio_hi == 8'h00)
		else $error("priority not cleared by reset");
	prio_reserved_a: assert property (@(posedge clk_in) disable iff (reset_in)
		state_q.prio_lo[7:4] == 4'h0 && state_q.prio_hi[7:4] == 4'h0)
		else $error("reserved priority bits set");
	prio_pair_a: assert property (@(posedge clk_in) disable iff (reset_in)
		timer5_prio_out == {state_q.prio_hi[2], state_q.prio_lo[2]})
		else $error("priority field misformed");
	level_follow_a: assert property (@(posedge clk_in) disable iff (reset_in)
		!$past(reset_in) && !state_q.edge_mode[0] && $stable(state_q.pin_cfg)
		&& $stable(state_q.edge_mode) |-> pending[0] ==
		($past(sel_pin_a) ~^ state_q.pin_cfg[A_POL_BIT]))
		else $error("level pending does not follow pin");
	level_follow_b_a: assert property (@(posedge clk_in) disable iff (reset_in)
		!$past(reset_in) && !state_q.edge_mode[1] && $stable(state_q.pin_cfg)
		&& $stable(state_q.edge_mode) |-> pending[1] ==
		($past(sel_pin_b) ~^ state_q.pin_cfg[B_POL_BIT]))
		else $error("second level pending does not follow pin");
	cfg_reset_a: assert property (@(posedge clk_in)
		$past(reset_in) |-> state_q.pin_cfg == PIN_CFG_RESET && state_q.edge_mode == EDGE_MODE_RESET
		&& state_q.status == STATUS_RESET && state_q.mask == MASK_RESET)
		else $error("configuration not reset");
	edge_set_first_a: assert property (@(posedge clk_in) disable iff (reset_in)
		edge_evt[0] |=> pending[0])
		else $error("first edge did not set pending");
	edge_rise_only_a: assert property (@(posedge clk_in) disable iff (reset_in)
		!$past(reset_in) && state_q.edge_mode[0] && $stable(state_q.edge_mode)
		&& $rose(pending[0]) |-> $past(edge_evt[0]))
		else $error("edge pending set without edge");
	edge_clear_b_a: assert property (@(posedge clk_in) disable iff (reset_in)
		state_q.edge_mode[1] && vector_ack_in[1] && !edge_evt[1]
		##1 state_q.edge_mode[1] |-> !pending[1])
		else $error("second vector did not clear pending");
	sw_ack_clear_a: assert property (@(posedge clk_in) disable iff (reset_in)
		wr_en && paddr_in[9:0] == VECTOR_ACK_ADDR && pwdata_in[1] && state_q.edge_mode[1]
		&& !edge_evt[1] ##1 state_q.edge_mode[1] |-> !pending[1])
		else $error("software ack did not clear pending");
	pend_readback_a: assert property (@(posedge clk_in) disable iff (reset_in)
		rd_en && paddr_in[9:0] == TIMER_CTRL_ADDR |=> prdata_out[A_PEND_BIT] == $past(pending[0])
		&& prdata_out[B_PEND_BIT] == $past(pending[1]))
		else $error("pending flags misplaced in read");
	prio_lo_write_a: assert property (@(posedge clk_in) disable iff (reset_in)
		wr_en && paddr_in[9:0] == PRIO_LO_ADDR |=> {tempsense_prio_out[0], timer5_prio_out[0],
		timer4_prio_out[0], serial1_prio_out[0]} == $past(wr_nibble))
		else $error("low priority write lost");
	prio_hi_write_a: assert property (@(posedge clk_in) disable iff (reset_in)
		wr_en && paddr_in[9:0] == PRIO_HI_ADDR |=> {tempsense_prio_out[1], timer5_prio_out[1],
		timer4_prio_out[1], serial1_prio_out[1]} == $past(wr_nibble))
		else $error("high priority write lost");
	status_w1c_a: assert property (@(posedge clk_in) disable iff (reset_in)
		wr_en && paddr_in[9:0] == IRQ_STATUS_ADDR && pwdata_in[0] && !edge_evt[0]
		&& (state_q.edge_mode[0] || !pending[0]) |=> !state_q.status[0])
		else $error("status bit not cleared");
	edge_set_a: assert property (@(posedge clk_in) disable iff (reset_in)
		edge_evt[1] |=> pending[1])
		else $error("edge did not set pending");
	edge_clear_a: assert property (@(posedge clk_in) disable iff (reset_in)
		state_q.edge_mode[0] && vector_ack_in[0] && !edge_evt[0]
		&& $stable(state_q.edge_mode) [*1] ##1 state_q.edge_mode[0] |-> !pending[0])
		else $error("vector did not clear pending");
	irq_level_a: assert property (@(posedge clk_in) disable iff (reset_in)
		|(edge_evt & state_q.mask) && !wr_en |=> irq_out)
		else $error("interrupt output wrong");
	sync_delay_a: assert property (@(posedge clk_in) disable iff (reset_in)
		!$past(reset_in) && !$past(reset_in, 2) |-> pins_sync == $past(port0_pins_in, 2))
		else $error("pin sync delay wrong");
	edge_cov: cover property (@(posedge clk_in) disable iff (reset_in) edge_evt[0]);
	ack_cov: cover property (@(posedge clk_in) disable iff (reset_in)
		pending[0] && vector_ack_in[0]);
	irq_cov: cover property (@(posedge clk_in) disable iff (reset_in) irq_out);
	level_cov: cover property (@(posedge clk_in) disable iff (reset_in)
		!state_q.edge_mode[0] && pending[0] && !state_q.pin_cfg[A_POL_BIT]);
	swack_cov: cover property (@(posedge clk_in) disable iff (reset_in) sw_ack[1] && pending[1]);
endmodule // ext_irq_config_priority

// ### inc/ext_irq_pkg.sv
package ext_irq_pkg;
	// Register byte addresses: printed offsets are not all multiples of four,
	// so each printed offset is an index and the byte address is four times it
	localparam logic [7:0]  PRIO_HI_IDX      = 8'h86;
	localparam logic [7:0]  PRIO_LO_IDX      = 8'hBF;
	localparam logic [7:0]  PIN_CFG_IDX      = 8'hE4;
	localparam logic [7:0]  TIMER_CTRL_IDX   = 8'h88;
	localparam logic [7:0]  IRQ_STATUS_IDX   = 8'hF0;
	localparam logic [7:0]  IRQ_MASK_IDX     = 8'hF1;
	localparam logic [7:0]  VECTOR_ACK_IDX   = 8'hF2;
	localparam int          ADDR_W           = 10;
	localparam logic [9:0]  PRIO_HI_ADDR     = {PRIO_HI_IDX, 2'b00};
	localparam logic [9:0]  PRIO_LO_ADDR     = {PRIO_LO_IDX, 2'b00};
	localparam logic [9:0]  PIN_CFG_ADDR     = {PIN_CFG_IDX, 2'b00};
	localparam logic [9:0]  TIMER_CTRL_ADDR  = {TIMER_CTRL_IDX, 2'b00};
	localparam logic [9:0]  IRQ_STATUS_ADDR  = {IRQ_STATUS_IDX, 2'b00};
	localparam logic [9:0]  IRQ_MASK_ADDR    = {IRQ_MASK_IDX, 2'b00};
	localparam logic [9:0]  VECTOR_ACK_ADDR  = {VECTOR_ACK_IDX, 2'b00};
	// Field positions
	localparam int          PRIO_FIELD_W     = 4;
	localparam int          A_SEL_LSB        = 0;
	localparam int          A_POL_BIT        = 3;
	localparam int          B_SEL_LSB        = 4;
	localparam int          B_POL_BIT        = 7;
	localparam int          A_EDGE_BIT       = 0;
	localparam int          A_PEND_BIT       = 1;
	localparam int          B_EDGE_BIT       = 2;
	localparam int          B_PEND_BIT       = 3;
	// Reset values
	localparam logic [7:0]  PRIO_RESET       = 8'h00;
	localparam logic [7:0]  PIN_CFG_RESET    = 8'h01;
	localparam logic [1:0]  EDGE_MODE_RESET  = 2'h0;
	localparam logic [1:0]  STATUS_RESET     = 2'h0;
	localparam logic [1:0]  MASK_RESET       = 2'h0;
endpackage

// ### rtl/pin_sync.sv
`timescale 1ns/100ps
module pin_sync (
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	input  wire logic [7:0] pins_in,
	output logic      [7:0] pins_out
);
	typedef struct packed {
		logic [7:0] first;
		logic [7:0] second;
	} sync_s;
	sync_s state_q;
	sync_s state_d;
	always_comb begin
		state_d.first  = pins_in;
		state_d.second = state_q.first;
	end
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end
	assign pins_out = state_q.second;
endmodule // pin_sync

// ### rtl/irq_detect.sv
`timescale 1ns/100ps
module irq_detect (
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	input  wire logic [7:0] pins_in,
	input  wire logic [2:0] pin_sel_in,
	input  wire logic       polarity_in,
	input  wire logic       edge_mode_in,
	input  wire logic       vector_ack_in,
	output logic            pending_out,
	output logic            active_out,
	output logic            edge_out
);
	typedef struct packed {
		logic last_active;
		logic edge_flag;
	} det_s;
	det_s state_q;
	det_s state_d;
	logic active;
	assign active = pins_in[pin_sel_in] ~^ polarity_in;
	always_comb begin
		state_d             = state_q;
		state_d.last_active = active;
		if (vector_ack_in) begin
			state_d.edge_flag = 1'b0;
		end
		if (edge_mode_in && active && !state_q.last_active) begin
			state_d.edge_flag = 1'b1;
		end
	end
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end
	assign pending_out = edge_mode_in ? state_q.edge_flag : state_q.last_active;
	assign active_out  = state_q.last_active;
	assign edge_out    = edge_mode_in && active && !state_q.last_active;
endmodule // irq_detect

// ### test/irq_source_model.sv
`timescale 1ns/100ps
module irq_source_model (
	input  wire logic       clk_in,
	input  wire logic       slow_in,
	input  wire logic [7:0] level_in,
	output logic      [7:0] pins_out
);
	logic [7:0] stage_q [4];
	// Requests held as commanded until the bench drops them
	always_ff @(posedge clk_in) begin
		stage_q[0] <= level_in;
		for (int i = 1; i < 4; i++) begin
			stage_q[i] <= stage_q[i - 1];
		end
	end
	// Prompt or slow source
	// Pins dedicated to the sources, nothing else drives them
	assign pins_out = slow_in ? stage_q[3] : stage_q[0];
endmodule // irq_source_model

// ### test/tb_ext_irq_config_priority.sv
`timescale 1ns/100ps
module tb_ext_irq_config_priority;
	import ext_irq_pkg::*;
	logic        clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic        psel_in = 1'b0;
	logic        penable_in = 1'b0;
	logic        pwrite_in = 1'b0;
	logic [31:0] paddr_in = 32'h0;
	logic [31:0] pwdata_in = 32'h0;
	logic [31:0] prdata_out;
	logic        pready_out;
	logic        pslverr_out;
	logic [7:0]  port0_pins_in;
	logic [1:0]  vector_ack_in = 2'h0;
	logic [1:0]  ext_irq_request_out;
	logic [1:0]  ts_prio, t5_prio, t4_prio, s1_prio;
	logic        irq_out;
	logic        slow_in = 1'b0;
	logic [7:0]  level_in = 8'h00;
	int          num_errors = 0;
	int          total_checks = 0;
	logic [31:0] rd;
	logic        err;

	always #5 clk_in = ~clk_in;

	irq_source_model irq_source_model_inst (.clk_in(clk_in), .slow_in(slow_in),
		.level_in(level_in), .pins_out(port0_pins_in));

	ext_irq_config_priority ext_irq_config_priority_inst (.clk_in(clk_in),
		.reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
		.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
		.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
		.port0_pins_in(port0_pins_in), .vector_ack_in(vector_ack_in),
		.ext_irq_request_out(ext_irq_request_out), .tempsense_prio_out(ts_prio),
		.timer5_prio_out(t5_prio), .timer4_prio_out(t4_prio),
		.serial1_prio_out(s1_prio), .irq_out(irq_out));

	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	// One APB transfer, held until pready
	task automatic apb(input logic wr, input logic [9:0] addr, input logic [31:0] wd);
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= wr;
		paddr_in <= {22'h0, addr};
		pwdata_in <= wd;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask

	task automatic wr(input logic [9:0] addr, input logic [31:0] wd);
		apb(1'b1, addr, wd);
	endtask

	task automatic rdchk(input string name, input logic [9:0] addr, input logic [31:0] exp);
		apb(1'b0, addr, 32'h0);
		chk(name, exp, rd);
	endtask

	task automatic drive(input logic [7:0] v);
		level_in <= v;
		tick(8);
	endtask

	task automatic ack(input logic [1:0] v);
		vector_ack_in <= v;
		@(posedge clk_in);
		vector_ack_in <= 2'h0;
		tick(1);
	endtask

	initial begin
		#100000;
		num_errors++;
		test_done();
	end

	initial begin
		repeat (3) @(posedge clk_in);
		reset_in <= 1'b0;
		rdchk("prio_hi", PRIO_HI_ADDR, 32'h0);
		rdchk("prio_lo", PRIO_LO_ADDR, 32'h0);
		rdchk("pin_cfg", PIN_CFG_ADDR, 32'h1);
		rdchk("timer_ctrl", TIMER_CTRL_ADDR, 32'hA);
		wr(PRIO_LO_ADDR, 32'h0F);
		wr(PRIO_HI_ADDR, 32'h06);
		rdchk("prio_lo", PRIO_LO_ADDR, 32'h0F);
		rdchk("prio_hi", PRIO_HI_ADDR, 32'h06);
		chk("prio_fields", 32'h7D, {24'h0, ts_prio, t5_prio, t4_prio, s1_prio});
		apb(1'b0, 10'h004, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		chk("unmapped_rd", 32'h0, rd);
		// Pin select sweep, level mode, active high
		for (int n = 0; n < 8; n++) begin
			wr(PIN_CFG_ADDR, {24'h0, 1'b1, 3'(7 - n), 1'b1, 3'(n)});
			drive(8'h01 << n);
			rdchk("pend_a_sel", TIMER_CTRL_ADDR, 32'h2);
			drive(8'h80 >> n);
			rdchk("pend_b_sel", TIMER_CTRL_ADDR, 32'h8);
		end
		slow_in <= 1'b1;
		wr(PIN_CFG_ADDR, 32'h63);
		drive(8'hFF);
		rdchk("low_idle", TIMER_CTRL_ADDR, 32'h0);
		drive(8'h00);
		rdchk("low_active", TIMER_CTRL_ADDR, 32'hA);
		drive(8'h08);
		rdchk("low_mixed", TIMER_CTRL_ADDR, 32'h8);
		// Edge mode with interrupt status and mask
		wr(PIN_CFG_ADDR, 32'h6B);
		drive(8'h00);
		wr(TIMER_CTRL_ADDR, 32'h5);
		wr(IRQ_STATUS_ADDR, 32'h3);
		rdchk("edge_idle", TIMER_CTRL_ADDR, 32'h5);
		drive(8'h08);
		rdchk("edge_a", TIMER_CTRL_ADDR, 32'h7);
		chk("request_a", 32'h1, {30'h0, ext_irq_request_out});
		chk("irq_masked", 32'h0, {31'h0, irq_out});
		wr(IRQ_MASK_ADDR, 32'h1);
		tick(2);
		chk("irq_on", 32'h1, {31'h0, irq_out});
		rdchk("status", IRQ_STATUS_ADDR, 32'h1);
		ack(2'b01);
		rdchk("ack_a", TIMER_CTRL_ADDR, 32'h5);
		wr(IRQ_STATUS_ADDR, 32'h1);
		tick(2);
		chk("irq_off", 32'h0, {31'h0, irq_out});
		drive(8'h40);
		drive(8'h00);
		rdchk("edge_b", TIMER_CTRL_ADDR, 32'hD);
		chk("request_b", 32'h2, {30'h0, ext_irq_request_out});
		chk("irq_b_masked", 32'h0, {31'h0, irq_out});
		ack(2'b10);
		rdchk("ack_b", TIMER_CTRL_ADDR, 32'h5);
		rdchk("vec_ack_rd", VECTOR_ACK_ADDR, 32'h0);
		wr(IRQ_STATUS_ADDR, 32'h2);
		wr(IRQ_MASK_ADDR, 32'h2);
		drive(8'h40);
		drive(8'h00);
		chk("irq_b_on", 32'h1, {31'h0, irq_out});
		rdchk("edge_b2", TIMER_CTRL_ADDR, 32'hD);
		wr(VECTOR_ACK_ADDR, 32'h2);
		rdchk("sw_ack_b", TIMER_CTRL_ADDR, 32'h5);
		test_done();
	end
endmodule // tb_ext_irq_config_priority
